// ### dbc_event_counter.sv
// Overview of operation
// - Data compare 1 link ties it to instruction compare 1; that compare skips status.
// - Linked data compare 1 counts only if the same instruction hit compare 1.
// - Data compare 2 link ties it to instruction compare 3 likewise.
// - Lower data compare config bits (19:0) are reserved and read as zero.
// - Main control compare enables are ignored for counting.
// - Compare configuration still shapes counted events without status recording.
// - Each counter decrements at most once per instruction.
// - Multiple-word access with many hits gives exactly one decrement.
// - Interrupted multiple-word access gives no count.
// - Independent counters may both decrement for one instruction.
// - Pairing bit selects two 16-bit counters or one 32-bit counter.
// - Counter enabled when any own count enable set and a debug mode on.
// - Counter 2 counts completes, compares and external events.
// - Counter 1 triggers: compares 1, 3, data read, write, externals, counter 2.
// - Any trigger enable set freezes counter 1 until a trigger fires.
// - Triggered status reported; clearing it re-arms the trigger.
// - Mixed instruction and data counting may raise the event late.
// - Counters run whether or not exceptions are enabled.
// - Counter 2 events are not blocked while triggering counter 1.
// - One count enable bit per event per counter.
`timescale 1ns/1ps
`default_nettype none
`include "dbc_defs.svh"

module dbc_event_counter
  import dbc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic        clkEn,
  input  wire logic [2:0]  sprSel,
  input  wire logic        sprWrite,
  input  wire logic        sprRead,
  input  wire logic [31:0] sprWdata,
  output logic      [31:0] sprRdata,
  output logic             sprRdValid,
  input  wire logic [3:0]  iacHit,
  input  wire logic [1:0]  dacReadHit,
  input  wire logic [1:0]  dacWriteHit,
  input  wire logic        insnComplete,
  input  wire logic        insnAbort,
  input  wire logic        irptTaken,
  input  wire logic        irptExit,
  input  wire logic        extEventOnePin,
  input  wire logic        extEventTwoPin,
  output logic             counterDebugEvent,
  output logic             counterOneTriggered
);

  localparam int HW = `DBC_HALF_W;

  dbc_state_t s_q;
  dbc_state_t s_d;

  dbc_cnt_if #(.W(HW)) cntOne ();
  dbc_cnt_if #(.W(HW)) cntTwo ();

  // ==========================================================
  // Counter halves: counter 1 is the upper half of the word
  dbc_down_counter #(.W(HW)) uCntOne (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .cnt     (cntOne.owner)
  );

  dbc_down_counter #(.W(HW)) uCntTwo (
    .ref_clk (ref_clk),
    .reset   (reset),
    .clkEn   (clkEn),
    .cnt     (cntTwo.owner)
  );

  // ==========================================================
  // Event qualification
  logic [1:0]  extEvt;
  logic [3:0]  iacNow;
  logic [1:0]  rdNow;
  logic [1:0]  wrNow;
  logic        commit;
  logic        link1;
  logic        link2;
  logic        exactMode;
  logic [1:0]  effRd;
  logic [1:0]  effWr;
  logic [3:0]  iacC;
  logic [1:0]  rdC;
  logic [1:0]  wrC;
  logic        doneC;
  logic [12:0] evVec;
  logic        dbgOn;
  logic        paired;
  logic        en1;
  logic        en2;
  logic [6:0]  trgSel;
  logic [6:0]  trgSrc;
  logic        trgHit;
  logic        run1;
  logic        dec1;
  logic        dec2;
  logic        zero1;
  logic        zero2;
  logic [31:0] wide;
  logic [7:0]  stSet;

  always_comb begin
    extEvt    = s_q.extSync2 & ~s_q.extPrev;
    iacNow    = s_q.pendIac | iacHit;
    rdNow     = s_q.pendRd | dacReadHit;
    wrNow     = s_q.pendWr | dacWriteHit;
    // Abort wins: an interrupted multi-word access leaves nothing behind
    commit    = insnComplete & ~insnAbort;
    link1     = s_q.dataCfg[`DBC_DCFG_LNK1];
    link2     = s_q.dataCfg[`DBC_DCFG_LNK2];
    exactMode = s_q.dataCfg[`DBC_DCFG_MODE_HI:`DBC_DCFG_MODE_LO] == `DBC_MODE_EXACT;
    // Linked data hits stand only beside the matching instruction hit
    effRd[0]  = rdNow[0] & (~link1 | iacNow[0]);
    effWr[0]  = wrNow[0] & (~link1 | iacNow[0]);
    // No second data compare outside exact address mode
    effRd[1]  = rdNow[1] & exactMode & (~link2 | iacNow[2]);
    effWr[1]  = wrNow[1] & exactMode & (~link2 | iacNow[2]);
    // Hits gathered over the instruction collapse into one count point
    iacC      = commit ? iacNow : 4'h0;
    rdC       = commit ? effRd : 2'h0;
    wrC       = commit ? effWr : 2'h0;
    doneC     = commit;
    evVec     = {extEvt[0], extEvt[1], doneC, iacC[0], iacC[1], iacC[2], iacC[3],
                 rdC[0], wrC[0], rdC[1], wrC[1], irptTaken, irptExit};
  end

  // ==========================================================
  // Counter enables, trigger and decrement
  always_comb begin
    dbgOn  = s_q.mainCtl[`DBC_CTL_IDM] | s_q.mainCtl[`DBC_CTL_EXTDBG];
    paired = s_q.cntCtl[`DBC_CC_PAIRED];
    // Main control compare enables play no part here
    en1    = |s_q.cntCtl[`DBC_CC_C1_HI:`DBC_CC_C1_LO] & dbgOn;
    en2    = |s_q.cntCtl[`DBC_CC_C2_HI:`DBC_CC_C2_LO] & dbgOn & ~paired;
    // Counter 2 has no interrupt taken or exit enables
    dec2   = en2 & |(evVec[12:2] & s_q.cntCtl[`DBC_CC_C2_HI:`DBC_CC_C2_LO]);
    zero2  = dec2 & (cntTwo.value == HW'(1));
    trgSel = s_q.cntCtl[`DBC_CC_TRG_HI:`DBC_CC_TRG_LO];
    trgSrc = {extEvt[0], extEvt[1], iacC[0], iacC[2], rdC[0], wrC[0], zero2};
    trgHit = |(trgSel & trgSrc);
    // Frozen while armed and not yet triggered
    run1   = (trgSel == 7'h0) | s_q.status[`DBC_ST_TRG];
    // One decrement per count point whatever the number of hits
    dec1   = en1 & run1 & |(evVec & s_q.cntCtl[`DBC_CC_C1_HI:`DBC_CC_C1_LO]);
    wide   = {cntOne.value, cntTwo.value};
    // Exceptions play no part: counters run on their own enables
    if (paired) begin
      zero1 = dec1 & (wide == 32'h0000_0001);
    end else begin
      zero1 = dec1 & (cntOne.value == HW'(1));
    end
  end

  // ==========================================================
  // Counter halves steering
  always_comb begin
    cntOne.load    = sprWrite & (sprSel == `DBC_SEL_COUNTER);
    cntTwo.load    = cntOne.load;
    cntOne.loadVal = sprWdata[31:HW];
    cntTwo.loadVal = sprWdata[HW-1:0];
    if (paired) begin
      // Lower half borrows into the upper half
      cntTwo.dec = dec1;
      cntOne.dec = dec1 & (cntTwo.value == HW'(0));
    end else begin
      cntTwo.dec = dec2;
      cntOne.dec = dec1;
    end
  end

  // ==========================================================
  // Status set terms
  always_comb begin
    stSet = s_q.mainCtl[`DBC_CTL_EN_HI:`DBC_CTL_EN_LO] &
            {iacC[0] & ~link1, iacC[1], iacC[2] & ~link2, iacC[3],
             rdC[0], wrC[0], rdC[1], wrC[1]};
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;

    // Pins cross in two stages; only the second is looked at
    s_d.extSync1 = {extEventTwoPin, extEventOnePin};
    s_d.extSync2 = s_q.extSync1;
    s_d.extPrev  = s_q.extSync2;

    // Gather hits until the instruction completes or is cut short
    if (insnComplete | insnAbort) begin
      s_d.pendIac = 4'h0;
      s_d.pendRd  = 2'h0;
      s_d.pendWr  = 2'h0;
    end else begin
      s_d.pendIac = iacNow;
      s_d.pendRd  = rdNow;
      s_d.pendWr  = wrNow;
    end

    if (sprWrite) begin
      unique case (sprSel)
        `DBC_SEL_MAIN_CTL: s_d.mainCtl = sprWdata;
        `DBC_SEL_INSN_CFG: s_d.insnCfg = sprWdata;
        `DBC_SEL_DATA_CFG: s_d.dataCfg = sprWdata & ~`DBC_DCFG_RSVD_MASK;
        // Arming and enabling arrive together in one write
        `DBC_SEL_CNT_CTL:  s_d.cntCtl = sprWdata;
        `DBC_SEL_STATUS:   s_d.status = s_q.status & ~sprWdata;
        default:           s_d.status = s_d.status;
      endcase
    end

    // Set wins over a clear in the same cycle
    s_d.status[`DBC_ST_EVT_HI:`DBC_ST_EVT_LO] =
      s_d.status[`DBC_ST_EVT_HI:`DBC_ST_EVT_LO] | stSet;
    if (trgHit) begin
      s_d.status[`DBC_ST_TRG] = 1'b1;
    end
    if (zero1) begin
      s_d.status[`DBC_ST_CNT1] = 1'b1;
    end
    if (zero2) begin
      s_d.status[`DBC_ST_CNT2] = 1'b1;
    end
    // Raised when the count lands, not aligned to the instruction
    s_d.dbgEvent = zero1 | zero2;

    s_d.rdValid = sprRead;
    if (sprRead) begin
      unique case (sprSel)
        `DBC_SEL_MAIN_CTL: s_d.rdData = s_q.mainCtl;
        `DBC_SEL_INSN_CFG: s_d.rdData = s_q.insnCfg;
        `DBC_SEL_DATA_CFG: s_d.rdData = s_q.dataCfg;
        `DBC_SEL_CNT_CTL:  s_d.rdData = s_q.cntCtl;
        `DBC_SEL_STATUS:   s_d.rdData = s_q.status;
        `DBC_SEL_COUNTER:  s_d.rdData = wide;
        default:           s_d.rdData = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q         <= '0;
      s_q.mainCtl <= `DBC_RST_WORD;
      s_q.dataCfg <= `DBC_RST_WORD;
      s_q.cntCtl  <= `DBC_RST_WORD;
      s_q.status  <= `DBC_RST_WORD;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign sprRdata            = s_q.rdData;
  assign sprRdValid          = s_q.rdValid;
  assign counterDebugEvent   = s_q.dbgEvent;
  assign counterOneTriggered = s_q.status[`DBC_ST_TRG];

endmodule // dbc_event_counter

`default_nettype wire

// ### dbc_defs.svh
`ifndef DBC_DEFS_SVH
`define DBC_DEFS_SVH

// ==========================================================
// Register select codes on the special-register port
`define DBC_SEL_MAIN_CTL   3'h0
`define DBC_SEL_INSN_CFG   3'h1
`define DBC_SEL_DATA_CFG   3'h2
`define DBC_SEL_CNT_CTL    3'h3
`define DBC_SEL_STATUS     3'h4
`define DBC_SEL_COUNTER    3'h5

// ==========================================================
// Reset values
`define DBC_RST_WORD       32'h0000_0000

// ==========================================================
// main_debug_control fields
`define DBC_CTL_IDM        0
`define DBC_CTL_EXTDBG     1
`define DBC_CTL_EN_HI      31
`define DBC_CTL_EN_LO      24

// ==========================================================
// data_cmp_config fields
`define DBC_DCFG_MODE_HI   23
`define DBC_DCFG_MODE_LO   22
`define DBC_DCFG_LNK1      21
`define DBC_DCFG_LNK2      20
`define DBC_DCFG_RSVD_MASK 32'h000f_ffff
`define DBC_MODE_EXACT     2'h0

// ==========================================================
// counter_control fields
`define DBC_CC_C1_HI       31
`define DBC_CC_C1_LO       19
`define DBC_CC_C2_HI       18
`define DBC_CC_C2_LO       8
`define DBC_CC_TRG_HI      7
`define DBC_CC_TRG_LO      1
`define DBC_CC_PAIRED      0

// ==========================================================
// debug_status_reg fields
`define DBC_ST_EVT_HI      31
`define DBC_ST_EVT_LO      24
`define DBC_ST_CNT1        2
`define DBC_ST_CNT2        1
`define DBC_ST_TRG         0

// ==========================================================
// Counter halves
`define DBC_HALF_W         16

`endif

// ### dbc_pkg.sv
package dbc_pkg;

  // ==========================================================
  // State of the event counter control, apart from the two counter halves
  typedef struct packed {
    logic [31:0] mainCtl;
    logic [31:0] insnCfg;
    logic [31:0] dataCfg;
    logic [31:0] cntCtl;
    logic [31:0] status;
    logic [3:0]  pendIac;
    logic [1:0]  pendRd;
    logic [1:0]  pendWr;
    logic [1:0]  extSync1;
    logic [1:0]  extSync2;
    logic [1:0]  extPrev;
    logic [31:0] rdData;
    logic        rdValid;
    logic        dbgEvent;
  } dbc_state_t;

endpackage

// ### dbc_cnt_if.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Carrier between the control and one down-counter
interface dbc_cnt_if #(parameter int W = 16);
  logic         load;
  logic [W-1:0] loadVal;
  logic         dec;
  logic [W-1:0] value;

  modport owner (input load, input loadVal, input dec, output value);
  modport user  (output load, output loadVal, output dec, input value);
endinterface

`default_nettype wire

// ### dbc_down_counter.sv
`timescale 1ns/1ps
`default_nettype none

module dbc_down_counter #(
  parameter int W = 16
) (
  input  wire logic   ref_clk,
  input  wire logic   reset,
  input  wire logic   clkEn,
  dbc_cnt_if.owner    cnt
);

  typedef struct packed {
    logic [W-1:0] value;
  } dbc_cnt_state_t;

  dbc_cnt_state_t s_q;
  dbc_cnt_state_t s_d;

  // ==========================================================
  // Load beats decrement so a software write is never lost
  always_comb begin
    s_d = s_q;
    if (cnt.load) begin
      s_d.value = cnt.loadVal;
    end else if (cnt.dec) begin
      s_d.value = s_q.value - W'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s_q <= '0;
    end else if (clkEn) begin
      s_q <= s_d;
    end
  end

  assign cnt.value = s_q.value;

endmodule // dbc_down_counter

`default_nettype wire

// ### dbc_event_counter_checker.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Port checks of the event counter control
module dbc_event_counter_checker (
  input wire logic        ref_clk,
  input wire logic        reset,
  input wire logic        clkEn,
  input wire logic [2:0]  sprSel,
  input wire logic        sprWrite,
  input wire logic        sprRead,
  input wire logic [31:0] sprWdata,
  input wire logic [31:0] sprRdata,
  input wire logic        sprRdValid,
  input wire logic        counterDebugEvent,
  input wire logic        counterOneTriggered
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  wire logic rdT = clkEn && sprRead;

  chk_rd_valid: assert property (rdT |=> sprRdValid)
    else $error("no read valid");
  chk_valid_cause: assert property (clkEn && !sprRead |=> !sprRdValid)
    else $error("stray read valid");
  chk_unmapped_zero: assert property (rdT && sprSel > 3'h5 |=> sprRdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rsvd_zero: assert property (rdT && sprSel == 3'h2 |=> sprRdata[19:0] == 20'h0)
    else $error("reserved bits set");
  chk_cfg_readback: assert property (
    (clkEn && sprWrite && sprSel == 3'h2) ##1 (clkEn && !sprWrite)
    ##1 (rdT && !sprWrite && sprSel == 3'h2)
    |=> sprRdata == ($past(sprWdata, 3) & 32'hfff0_0000))
    else $error("config readback wrong");
  chk_trig_sticky: assert property (
    counterOneTriggered && !(clkEn && sprWrite && sprSel == 3'h4 && sprWdata[0])
    |=> counterOneTriggered)
    else $error("trigger status lost");
  chk_status_trig: assert property (
    rdT && sprSel == 3'h4 |=> sprRdata[0] == $past(counterOneTriggered))
    else $error("trigger status mismatch");
  // Frozen clock enable must hold trigger status, read data and debug event
  chk_freeze_hold: assert property (!clkEn |=> $stable(counterOneTriggered) && $stable(sprRdata)
    && $stable(counterDebugEvent))
    else $error("state moved while frozen");
endmodule // dbc_event_counter_checker

bind dbc_event_counter dbc_event_counter_checker i_dbc_event_counter_checker (
  .ref_clk, .reset, .clkEn, .sprSel, .sprWrite, .sprRead, .sprWdata,
  .sprRdata, .sprRdValid, .counterDebugEvent, .counterOneTriggered);

`default_nettype wire

// ### dbc_pipe_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Pipeline event detectors
module dbc_pipe_model (
  input  wire logic       ref_clk,
  output logic      [3:0] iacHit,
  output logic      [1:0] dacReadHit,
  output logic      [1:0] dacWriteHit,
  output logic            insnComplete,
  output logic            insnAbort
);
  initial begin
    {iacHit, dacReadHit, dacWriteHit, insnComplete, insnAbort} = '0;
  end
  // Hits spread over n cycles, as a multiple-word access gives
  task automatic run(input logic [3:0] iac, input logic [1:0] rd, input logic [1:0] wr,
                     input int n, input logic ab);
    repeat (n) begin
      @(posedge ref_clk);
      iacHit <= iac;
      dacReadHit <= rd;
      dacWriteHit <= wr;
    end
    @(posedge ref_clk);
    {iacHit, dacReadHit, dacWriteHit} <= '0;
    insnComplete <= !ab;
    insnAbort <= ab;
    @(posedge ref_clk);
    {insnComplete, insnAbort} <= '0;
  endtask
endmodule // dbc_pipe_model

`default_nettype wire

// ### tb_debug_event_counter_control.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Bench of the event counter control
module tb_debug_event_counter_control;
  logic             ref_clk, reset, clkEn, sprWrite, sprRead;
  logic             irptTaken, irptExit, extEventOnePin, extEventTwoPin;
  logic [2:0]       sprSel;
  logic [31:0]      sprWdata, v, r, e;
  wire logic [31:0] sprRdata;
  wire logic [3:0]  iacHit;
  wire logic [1:0]  dacReadHit, dacWriteHit;
  wire logic        sprRdValid, insnComplete, insnAbort, counterDebugEvent, counterOneTriggered;
  int               errors, n_checks, seed, nEvt, evBase;

  dbc_event_counter i_dbc_event_counter (.ref_clk, .reset, .clkEn, .sprSel, .sprWrite,
    .sprRead, .sprWdata, .sprRdata, .sprRdValid, .iacHit, .dacReadHit, .dacWriteHit,
    .insnComplete, .insnAbort, .irptTaken, .irptExit, .extEventOnePin, .extEventTwoPin,
    .counterDebugEvent, .counterOneTriggered);
  dbc_pipe_model i_dbc_pipe_model (.ref_clk, .iacHit, .dacReadHit, .dacWriteHit,
    .insnComplete, .insnAbort);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (counterDebugEvent === 1'b1) nEvt <= nEvt + 1;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] s, input logic [31:0] d);
    @(posedge ref_clk);
    sprSel <= s;
    sprWdata <= d;
    sprWrite <= 1'b1;
    @(posedge ref_clk);
    sprWrite <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] s, output logic [31:0] d);
    @(posedge ref_clk);
    sprSel <= s;
    sprRead <= 1'b1;
    @(posedge ref_clk);
    sprRead <= 1'b0;
    #1 d = sprRdata;
  endtask
  task automatic rc(input logic [2:0] s, input logic [31:0] exp);
    logic [31:0] d;
    rd(s, d);
    chk(d, exp);
  endtask
  task automatic insn(input logic [3:0] i, input logic [1:0] rr, input logic [1:0] ww,
                      input int n, input logic ab);
    i_dbc_pipe_model.run(i, rr, ww, n, ab);
    repeat (2) @(posedge ref_clk);
  endtask
  // Instruction compare enables of both counters
  function automatic logic [31:0] ccw(input logic [3:0] e1, input logic [3:0] e2);
    ccw = 32'h0;
    for (int i = 0; i < 4; i++) begin
      ccw[28 - i] = e1[i];
      ccw[15 - i] = e2[i];
    end
  endfunction
  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    seed = 33;
    {errors, n_checks} = '0;
    {reset, clkEn, sprWrite, sprRead, irptTaken, irptExit} = 6'h30;
    {extEventOnePin, extEventTwoPin, sprSel, sprWdata} = '0;
    repeat (16) @(posedge ref_clk);
    reset <= 1'b0;
    for (int s = 0; s < 8; s++) rc(3'(s), 32'h0);
    wr(3'h2, 32'hffff_ffff);
    rc(3'h2, 32'hfff0_0000);
    wr(3'h6, 32'hffff_ffff);
    rc(3'h6, 32'h0);
    $display("test registers done");
    wr(3'h5, 32'h0100_0100);
    e = 32'h0100_0100;
    for (int k = 0; k < 24; k++) begin
      v = $random(seed);
      r = $random(seed);
      wr(3'h0, v);
      wr(3'h3, ccw(r[3:0], r[7:4]));
      insn(r[11:8], 2'h0, 2'h0, int'(r[13:12]) + 1, r[15:14] == 2'h0);
      if (v[1:0] != 2'h0 && r[15:14] != 2'h0) begin
        e[31:16] -= 16'((r[3:0] & r[11:8]) != 4'h0);
        e[15:0] -= 16'((r[7:4] & r[11:8]) != 4'h0);
      end
      rc(3'h5, e);
    end
    $display("test random done");
    // Links left set by the register test would mask the data hits
    wr(3'h2, 32'h0);
    wr(3'h0, 32'h1);
    wr(3'h5, 32'h0005_0005);
    wr(3'h3, 32'h0100_0400);
    insn(4'h0, 2'h1, 2'h1, 3, 1'b0);
    rc(3'h5, 32'h0004_0004);
    insn(4'h0, 2'h1, 2'h1, 3, 1'b1);
    rc(3'h5, 32'h0004_0004);
    wr(3'h4, 32'hffff_ffff);
    wr(3'h5, 32'h0003_0001);
    wr(3'h3, 32'h0000_8000);
    evBase = nEvt;
    insn(4'h1, 2'h0, 2'h0, 1, 1'b0);
    rc(3'h4, 32'h2);
    chk(32'(nEvt - evBase), 32'h1);
    @(posedge ref_clk);
    clkEn <= 1'b0;
    insn(4'h1, 2'h0, 2'h0, 1, 1'b0);
    clkEn <= 1'b1;
    rc(3'h5, 32'h0003_0000);
    wr(3'h5, 32'h0001_0000);
    wr(3'h3, 32'h1000_0001);
    insn(4'h1, 2'h0, 2'h0, 1, 1'b0);
    rc(3'h5, 32'h0000_ffff);
    wr(3'h5, 32'h0003_0000);
    wr(3'h3, 32'h0018_0000);
    @(posedge ref_clk);
    irptTaken <= 1'b1;
    @(posedge ref_clk);
    irptTaken <= 1'b0;
    irptExit <= 1'b1;
    @(posedge ref_clk);
    irptExit <= 1'b0;
    rc(3'h5, 32'h0001_0000);
    $display("test counting done");
    for (int k = 0; k < 2; k++) begin
      wr(3'h0, k ? 32'h2000_0001 : 32'h8000_0001);
      wr(3'h2, k ? 32'h0010_0000 : 32'h0020_0000);
      wr(3'h3, k ? 32'h0000_0200 : 32'h0000_0800);
      wr(3'h5, 32'h9);
      wr(3'h4, 32'hffff_ffff);
      insn(4'h0, k ? 2'h2 : 2'h1, 2'h0, 2, 1'b0);
      rc(3'h5, 32'h9);
      insn(k ? 4'h4 : 4'h1, k ? 2'h2 : 2'h1, 2'h0, 2, 1'b0);
      rc(3'h5, 32'h8);
      rc(3'h4, 32'h0);
    end
    $display("test linking done");
    wr(3'h2, 32'h0);
    wr(3'h0, 32'h1);
    for (int k = 0; k < 7; k++) begin
      wr(3'h5, 32'h0005_0000 | 32'(k == 6));
      wr(3'h4, 32'hffff_ffff);
      // Last pass: counter 2 counts compare 2 hits and fires the trigger at zero
      e = k == 6 ? 32'h0000_4002 : 32'h1 << (k < 4 ? 5 - k : 11 - k);
      wr(3'h3, 32'h2000_0000 | e);
      insn(4'h0, 2'h0, 2'h0, 1, 1'b0);
      rc(3'h5, 32'h0005_0000 | 32'(k == 6));
      chk(32'(counterOneTriggered), 32'h0);
      if (k < 4 || k == 6) begin
        insn({1'b0, k == 1, k == 6, k == 0}, {1'b0, k == 2}, {1'b0, k == 3}, 1, 1'b0);
      end else begin
        @(posedge ref_clk);
        {extEventOnePin, extEventTwoPin} <= {k == 4, k == 5};
        repeat (6) @(posedge ref_clk);
        {extEventOnePin, extEventTwoPin} <= 2'b00;
      end
      chk(32'(counterOneTriggered), 32'h1);
      rc(3'h5, 32'h0005_0000);
      insn(4'h0, 2'h0, 2'h0, 1, 1'b0);
      rc(3'h5, 32'h0004_0000);
    end
    $display("test trigger done");
    summarize();
  end

  // Whole run needs under two thousand cycles
  initial begin
    #40000;
    errors++;
    summarize();
  end
endmodule // tb_debug_event_counter_control

`default_nettype wire
